// >>> verilog/tsrif_pkg.sv
package tsrif_pkg;
   // -------------------------------------------------------------
   // Frame constants
   // -------------------------------------------------------------
   localparam logic [7:0]  DELIM       = 8'h7E;
   localparam logic [7:0]  LEG_TYPE    = 8'h89;
   localparam logic [7:0]  RT_TYPE     = 8'h8D;
   localparam logic [7:0]  ST_OK       = 8'h00;
   localparam logic [7:0]  ST_NO_ACK   = 8'h01;
   localparam logic [7:0]  EVT_NACK    = 8'h11;
   localparam logic [7:0]  EVT_TRACE   = 8'h12;
   localparam logic [7:0]  RESERVED    = 8'h00;
   localparam logic [7:0]  CSUM_BASE   = 8'hFF;
   localparam logic [15:0] LEG_LEN     = 16'h0003;
   localparam logic [15:0] RT_LEN      = 16'h002A;
   localparam logic [7:0]  RT_TAIL_LEN = 8'h27;
   localparam int          BODY_W      = 336;
   localparam int          LEG_BODY_W  = 24;

   // -------------------------------------------------------------
   // Byte offsets
   // -------------------------------------------------------------
   localparam logic [5:0] OFS_DELIM   = 6'h00;
   localparam logic [5:0] OFS_LEN_MSB = 6'h01;
   localparam logic [5:0] OFS_LEN_LSB = 6'h02;
   localparam logic [5:0] OFS_TYPE    = 6'h03;
   localparam logic [5:0] OFS_ID      = 6'h04;
   localparam logic [5:0] OFS_STATUS  = 6'h05;
   localparam logic [5:0] OFS_EVT     = 6'h04;
   localparam logic [5:0] OFS_TLEN    = 6'h05;
   localparam logic [5:0] OFS_TS      = 6'h06;
   localparam logic [5:0] OFS_ACKTO   = 6'h0A;
   localparam logic [5:0] OFS_BLK     = 6'h0B;
   localparam logic [5:0] OFS_RSV     = 6'h0C;
   localparam logic [5:0] OFS_DST     = 6'h0D;
   localparam logic [5:0] OFS_SRC     = 6'h15;
   localparam logic [5:0] OFS_RSP     = 6'h1D;
   localparam logic [5:0] OFS_RCV     = 6'h25;
   localparam logic [5:0] OFS_RCV_LSB = 6'h2C;
   localparam logic [5:0] LEG_LAST    = 6'h06;
   localparam logic [5:0] RT_LAST     = 6'h2D;

   // -------------------------------------------------------------
   // Timing
   // -------------------------------------------------------------
   localparam int         US_NS         = 1000;
   localparam int         CLK_PERIOD_NS = 5;
   localparam logic [7:0] CYC_PER_US    = 8'(US_NS / CLK_PERIOD_NS);

   typedef enum logic [1:0] {
      ST_IDLE = 2'b01,
      ST_SEND = 2'b10
   } tsrif_state_t;
endpackage

// >>> verilog/tsrif_us_timer.sv
`timescale 1ns/10ps
module tsrif_us_timer (
   input  wire logic        clk,      // System clock
   input  wire logic        rst_n,    // Async reset, active low
   output logic      [31:0] us_count  // Free-running microseconds
);
   logic [7:0]  pre_reg;
   logic [7:0]  pre_next;
   logic [31:0] us_reg;
   logic [31:0] us_next;

   // Wraps after about 71 minutes; only differences are meaningful
   always_comb begin
      pre_next = pre_reg + 8'h01;
      us_next  = us_reg;
      if (pre_reg == tsrif_pkg::CYC_PER_US - 8'h01) begin
         pre_next = 8'h00;
         us_next  = us_reg + 32'h00000001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pre_reg <= 8'h00;
         us_reg  <= 32'h00000000;
      end else begin
         pre_reg <= pre_next;
         us_reg  <= us_next;
      end
   end

   assign us_count = us_reg;
endmodule // tsrif_us_timer

// >>> verilog/tsrif_framer.sv
`timescale 1ns/10ps
module tsrif_framer (
   input  wire logic        clk,             // System clock, 200 MHz
   input  wire logic        rst_n,           // Async reset, active low
   input  wire logic        leg_valid,       // Legacy request finished
   input  wire logic [7:0]  leg_frame_id,    // Its frame identifier
   input  wire logic        leg_no_ack,      // 1 = no ACK received
   output logic             leg_ready,       // Legacy report slot free
   input  wire logic        rt_valid,        // Route event
   input  wire logic        rt_trace,        // 1 = trace route, 0 = NACK
   input  wire logic [7:0]  rt_ack_timeouts, // MAC ACK timeout count
   input  wire logic [7:0]  rt_tx_blocked,   // Blocked-by-receive count
   input  wire logic [63:0] rt_dest_addr,    // Final destination
   input  wire logic [63:0] rt_src_addr,     // Originating source
   input  wire logic [63:0] rt_resp_addr,    // Reporting node
   input  wire logic [63:0] rt_recv_addr,    // Next-hop receiver
   output logic             rt_ready,        // Route report slot free
   output logic             tx_valid,        // Byte stream valid
   output logic      [7:0]  tx_data,         // Byte stream data
   output logic             tx_last,         // Checksum byte
   input  wire logic        tx_ready         // Host side takes byte
);
   // -------------------------------------------------------------
   // Timestamp source
   // -------------------------------------------------------------
   logic [31:0] us_now;

   tsrif_us_timer u_timer (
      .clk      (clk),
      .rst_n    (rst_n),
      .us_count (us_now)
   );

   // -------------------------------------------------------------
   // Report slots
   // -------------------------------------------------------------
   // One slot per frame kind, so a new report can be taken while
   // the other kind is on the wire.
   logic                         leg_pend_reg, leg_pend_next;
   logic [7:0]                   leg_id_reg, leg_id_next;
   logic [7:0]                   leg_st_reg, leg_st_next;
   logic                         rt_pend_reg, rt_pend_next;
   logic [tsrif_pkg::BODY_W-1:0] rt_body_reg, rt_body_next;
   logic                         leg_done, rt_done;

   always_comb begin
      leg_pend_next = leg_pend_reg;
      leg_id_next   = leg_id_reg;
      leg_st_next   = leg_st_reg;
      rt_pend_next  = rt_pend_reg;
      rt_body_next  = rt_body_reg;
      if (leg_done) begin
         leg_pend_next = 1'b0;
      end
      if (rt_done) begin
         rt_pend_next = 1'b0;
      end
      if (leg_valid && leg_ready) begin
         leg_pend_next = 1'b1;
         leg_id_next   = leg_frame_id;
         leg_st_next   = leg_no_ack ? tsrif_pkg::ST_NO_ACK : tsrif_pkg::ST_OK;
      end
      if (rt_valid && rt_ready) begin
         rt_pend_next = 1'b1;
         // Addresses concatenated whole keep MSB first
         rt_body_next = {tsrif_pkg::RT_TYPE,
                         rt_trace ? tsrif_pkg::EVT_TRACE : tsrif_pkg::EVT_NACK,
                         tsrif_pkg::RT_TAIL_LEN,
                         us_now,
                         rt_ack_timeouts,
                         rt_tx_blocked,
                         tsrif_pkg::RESERVED,
                         rt_dest_addr, rt_src_addr,
                         rt_resp_addr, rt_recv_addr};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         leg_pend_reg <= 1'b0;
         leg_id_reg   <= 8'h00;
         leg_st_reg   <= 8'h00;
         rt_pend_reg  <= 1'b0;
         rt_body_reg  <= '0;
         leg_ready    <= 1'b0;
         rt_ready     <= 1'b0;
      end else begin
         leg_pend_reg <= leg_pend_next;
         leg_id_reg   <= leg_id_next;
         leg_st_reg   <= leg_st_next;
         rt_pend_reg  <= rt_pend_next;
         rt_body_reg  <= rt_body_next;
         leg_ready    <= !leg_pend_next;
         rt_ready     <= !rt_pend_next;
      end
   end

   // -------------------------------------------------------------
   // Frame sequencer
   // -------------------------------------------------------------
   tsrif_pkg::tsrif_state_t state_reg, state_next;
   logic       is_rt_reg, is_rt_next;
   logic [5:0] idx_reg, idx_next;
   logic [7:0] sum_reg, sum_next;
   logic       valid_next, last_next;
   logic [7:0] data_next;
   logic [5:0] last_idx;

   assign last_idx = is_rt_reg ? tsrif_pkg::RT_LAST : tsrif_pkg::LEG_LAST;
   assign leg_done = (state_reg == tsrif_pkg::ST_SEND) && !is_rt_reg && tx_ready && tx_last;
   assign rt_done  = (state_reg == tsrif_pkg::ST_SEND) && is_rt_reg && tx_ready && tx_last;

   always_comb begin
      state_next = state_reg;
      is_rt_next = is_rt_reg;
      idx_next   = idx_reg;
      sum_next   = sum_reg;
      valid_next = tx_valid;
      case (state_reg)
         tsrif_pkg::ST_IDLE: begin
            // Legacy report goes first when both wait
            if (leg_pend_reg || rt_pend_reg) begin
               state_next = tsrif_pkg::ST_SEND;
               is_rt_next = !leg_pend_reg;
               idx_next   = tsrif_pkg::OFS_DELIM;
               sum_next   = 8'h00;
               valid_next = 1'b1;
            end
         end
         tsrif_pkg::ST_SEND: begin
            if (tx_ready) begin
               if (tx_last) begin
                  state_next = tsrif_pkg::ST_IDLE;
                  valid_next = 1'b0;
               end else begin
                  idx_next = idx_reg + 6'h01;
                  if (idx_reg >= tsrif_pkg::OFS_TYPE) begin
                     sum_next = sum_reg + tx_data;
                  end
               end
            end
         end
         default: begin
            state_next = tsrif_pkg::ST_IDLE;
            valid_next = 1'b0;
         end
      endcase
   end

   // -------------------------------------------------------------
   // Byte selection
   // -------------------------------------------------------------
   logic [tsrif_pkg::BODY_W-1:0] body, body_sh;
   logic [15:0]                  flen;
   logic [5:0]                   nlast;

   always_comb begin
      body    = is_rt_next ? rt_body_reg
                           : {tsrif_pkg::LEG_TYPE, leg_id_reg, leg_st_reg,
                              {(tsrif_pkg::BODY_W - tsrif_pkg::LEG_BODY_W){1'b0}}};
      flen    = is_rt_next ? tsrif_pkg::RT_LEN : tsrif_pkg::LEG_LEN;
      nlast   = is_rt_next ? tsrif_pkg::RT_LAST : tsrif_pkg::LEG_LAST;
      body_sh = body << {idx_next - tsrif_pkg::OFS_TYPE, 3'b000};
      last_next = valid_next && (idx_next == nlast);
      if (idx_next == tsrif_pkg::OFS_DELIM) begin
         data_next = tsrif_pkg::DELIM;
      end else if (idx_next == tsrif_pkg::OFS_LEN_MSB) begin
         data_next = flen[15:8];
      end else if (idx_next == tsrif_pkg::OFS_LEN_LSB) begin
         data_next = flen[7:0];
      end else if (idx_next == nlast) begin
         data_next = tsrif_pkg::CSUM_BASE - sum_next;
      end else begin
         data_next = body_sh[tsrif_pkg::BODY_W-1 -: 8];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= tsrif_pkg::ST_IDLE;
         is_rt_reg <= 1'b0;
         idx_reg   <= 6'h00;
         sum_reg   <= 8'h00;
         tx_valid  <= 1'b0;
         tx_data   <= 8'h00;
         tx_last   <= 1'b0;
      end else begin
         state_reg <= state_next;
         is_rt_reg <= is_rt_next;
         idx_reg   <= idx_next;
         sum_reg   <= sum_next;
         tx_valid  <= valid_next;
         tx_data   <= valid_next ? data_next : tx_data;
         tx_last   <= last_next;
      end
   end

   // -------------------------------------------------------------
   // Assertions
   // -------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   logic leg_at, rt_at;
   assign leg_at = tx_valid && !is_rt_reg;
   assign rt_at  = tx_valid && is_rt_reg;

   property p_leg_type;
      leg_at && idx_reg == tsrif_pkg::OFS_TYPE |-> tx_data == tsrif_pkg::LEG_TYPE;
   endproperty
   a_leg_type: assert property (p_leg_type) else $error("legacy type byte wrong");

   property p_leg_id;
      leg_at && idx_reg == tsrif_pkg::OFS_ID |-> tx_data == leg_id_reg;
   endproperty
   a_leg_id: assert property (p_leg_id) else $error("legacy frame id wrong");

   // Status is captured at the take, sent at least two cycles later
   property p_leg_take;
      leg_valid && leg_ready
         |=> leg_st_reg == ($past(leg_no_ack) ? tsrif_pkg::ST_NO_ACK : tsrif_pkg::ST_OK);
   endproperty
   a_leg_take: assert property (p_leg_take) else $error("legacy status captured wrong");

   property p_leg_status;
      leg_at && idx_reg == tsrif_pkg::OFS_STATUS |-> tx_data == leg_st_reg;
   endproperty
   a_leg_status: assert property (p_leg_status) else $error("legacy status byte wrong");

   property p_rt_head;
      rt_at && idx_reg == tsrif_pkg::OFS_TYPE |-> tx_data == tsrif_pkg::RT_TYPE;
   endproperty
   a_rt_head: assert property (p_rt_head) else $error("route type wrong");

   property p_rt_evt;
      rt_at && idx_reg == tsrif_pkg::OFS_EVT |-> tx_data == tsrif_pkg::EVT_NACK || tx_data == tsrif_pkg::EVT_TRACE;
   endproperty
   a_rt_evt: assert property (p_rt_evt) else $error("route event code wrong");

   property p_rt_len;
      rt_at && idx_reg == tsrif_pkg::OFS_TLEN |-> tx_data == tsrif_pkg::RT_TAIL_LEN;
   endproperty
   a_rt_len: assert property (p_rt_len) else $error("route tail length wrong");

   property p_rt_rsv;
      rt_at && idx_reg == tsrif_pkg::OFS_RSV |-> tx_data == tsrif_pkg::RESERVED;
   endproperty
   a_rt_rsv: assert property (p_rt_rsv) else $error("reserved byte not zero");

   property p_rt_addr;
      rt_at && idx_reg == tsrif_pkg::OFS_DST |-> tx_data == rt_body_reg[255:248];
   endproperty
   a_rt_addr: assert property (p_rt_addr) else $error("destination MSB wrong");

   property p_rt_rcv;
      rt_at && idx_reg == tsrif_pkg::OFS_RCV_LSB |-> tx_data == rt_body_reg[7:0];
   endproperty
   a_rt_rcv: assert property (p_rt_rcv) else $error("receiver LSB wrong");

   property p_start;
      $rose(tx_valid) |-> tx_data == tsrif_pkg::DELIM && idx_reg == tsrif_pkg::OFS_DELIM;
   endproperty
   a_start: assert property (p_start) else $error("frame not opened by delimiter");

   property p_step;
      tx_valid && tx_ready && !tx_last |=> tx_valid && idx_reg == $past(idx_reg) + 6'h01;
   endproperty
   a_step: assert property (p_step) else $error("byte order broken");

   property p_hold;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while stalled");

   c_leg_frame: cover property (leg_at && tx_last && tx_ready);
   c_rt_frame:  cover property (rt_at && tx_last && tx_ready);
   c_both:      cover property (leg_valid && leg_ready && rt_valid && rt_ready);
endmodule // tsrif_framer

// >>> verif/tsrif_host_model.sv
`timescale 1ns/10ps
module tsrif_host_model (
   input  wire logic       clk,      // System clock
   input  wire logic       rst_n,    // Async reset, active low
   input  wire logic       stall_en, // Random back-pressure on
   input  wire logic       tx_valid, // Byte valid
   input  wire logic [7:0] tx_data,  // Byte data
   input  wire logic       tx_last,  // Checksum byte
   output logic            tx_ready, // Byte taken
   output logic            rx_stb,   // Byte received
   output logic      [7:0] rx_byte,  // Received byte
   output logic            rx_last   // Received byte was checksum
);
   int seed = 32'h5671dd58;

   // ----------------------------------------
   // Byte sink
   // ----------------------------------------
   // Every byte is passed on whole, so a longer tail count is never cut off
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_ready <= 1'b0;
         rx_stb   <= 1'b0;
         rx_byte  <= 8'h00;
         rx_last  <= 1'b0;
      end else begin
         tx_ready <= stall_en ? 1'($random(seed)) : 1'b1;
         rx_stb   <= tx_valid & tx_ready;
         rx_byte  <= tx_data;
         rx_last  <= tx_last;
      end
   end
endmodule // tsrif_host_model

// >>> verif/testbench.sv
`timescale 1ns/10ps
module testbench;
   logic        clk = 1'b0, rst_n = 1'b0, stall_en = 1'b0, in_frame = 1'b0;
   logic        leg_valid = 1'b0, leg_no_ack = 1'b0, rt_valid = 1'b0, rt_trace = 1'b0;
   logic [7:0]  leg_frame_id = 8'h00, rt_ack_timeouts = 8'h00, rt_tx_blocked = 8'h00;
   logic [63:0] rt_dest_addr = 64'h0, rt_src_addr = 64'h0, rt_resp_addr = 64'h0, rt_recv_addr = 64'h0;
   logic        leg_ready, rt_ready, tx_valid, tx_last, tx_ready, rx_stb, rx_last;
   logic [7:0]  tx_data, rx_byte, sum = 8'h00;
   logic [9:0]  e;
   logic [31:0] ts, ts_q[$], tk_q[$];
   logic [9:0]  exp_q[$];
   int          fail_count = 0, cmp_count = 0, cyc = 0, idx = 0, i, d, x;
   int          seed = 32'h5671dd58;

   always #2.5 clk = ~clk;

   tsrif_framer i_dut (.clk(clk), .rst_n(rst_n), .leg_valid(leg_valid), .leg_frame_id(leg_frame_id),
      .leg_no_ack(leg_no_ack), .leg_ready(leg_ready), .rt_valid(rt_valid), .rt_trace(rt_trace),
      .rt_ack_timeouts(rt_ack_timeouts), .rt_tx_blocked(rt_tx_blocked), .rt_dest_addr(rt_dest_addr),
      .rt_src_addr(rt_src_addr), .rt_resp_addr(rt_resp_addr), .rt_recv_addr(rt_recv_addr),
      .rt_ready(rt_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready));

   tsrif_host_model i_host (.clk(clk), .rst_n(rst_n), .stall_en(stall_en), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready), .rx_stb(rx_stb), .rx_byte(rx_byte),
      .rx_last(rx_last));

   task check(string name, logic [31:0] seen, logic [31:0] expv);
      cmp_count++;
      if (seen !== expv) begin
         fail_count++;
         $display("[FAIL] %s expected %0h seen %0h", name, expv, seen);
      end
   endtask

   task stop_test();
      $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   // Cuts a hang short; the whole run needs well under this
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   // ----------------------------------------
   // Expected frames; bit 9 marks checksum, bit 8 a timestamp byte
   // ----------------------------------------
   task hdr(logic [15:0] len, logic [7:0] typ);
      exp_q.push_back({2'b00, 8'h7E});
      exp_q.push_back({2'b00, len[15:8]});
      exp_q.push_back({2'b00, len[7:0]});
      exp_q.push_back({2'b00, typ});
   endtask

   task push_leg();
      hdr(16'h0003, 8'h89);
      exp_q.push_back({2'b00, leg_frame_id});
      exp_q.push_back({2'b00, 7'h00, leg_no_ack});
      exp_q.push_back(10'h200);
   endtask

   task push_rt();
      logic [255:0] a;
      a = {rt_dest_addr, rt_src_addr, rt_resp_addr, rt_recv_addr};
      hdr(16'h002A, 8'h8D);
      exp_q.push_back({2'b00, rt_trace ? 8'h12 : 8'h11});
      exp_q.push_back(10'h027);
      repeat (4) exp_q.push_back(10'h100);
      exp_q.push_back({2'b00, rt_ack_timeouts});
      exp_q.push_back({2'b00, rt_tx_blocked});
      exp_q.push_back(10'h000);
      for (int k = 31; k >= 0; k--) exp_q.push_back({2'b00, a[8*k+:8]});
      exp_q.push_back(10'h200);
   endtask

   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   task rnd(logic [1:0] k);
      leg_frame_id    <= 8'($random(seed));
      leg_no_ack      <= k[0];
      rt_trace        <= k[1];
      rt_ack_timeouts <= 8'($random(seed));
      rt_tx_blocked   <= 8'($random(seed));
      rt_dest_addr    <= {$random(seed), $random(seed)};
      rt_src_addr     <= {$random(seed), $random(seed)};
      rt_resp_addr    <= {$random(seed), $random(seed)};
      rt_recv_addr    <= {$random(seed), $random(seed)};
   endtask

   // Holds each valid until the edge that sees its ready high
   task req(bit l, bit r);
      leg_valid <= l;
      rt_valid  <= r;
      for (int n = 0; n < 500 && (l || r); n++) begin
         @(posedge clk);
         if (l && leg_ready === 1'b1) begin
            l = 0;
            leg_valid <= 1'b0;
            push_leg();
         end
         if (r && rt_ready === 1'b1) begin
            r = 0;
            rt_valid <= 1'b0;
            push_rt();
            tk_q.push_back(cyc);
         end
      end
      @(posedge clk);
      check("request_taken", {l, r}, 0);
   endtask

   task drain();
      for (int n = 0; n < 3000 && exp_q.size() > 0; n++) @(posedge clk);
      repeat (4) @(posedge clk);
      check("all_bytes_seen", exp_q.size(), 0);
   endtask

   // ----------------------------------------
   // Byte monitor
   // ----------------------------------------
   always @(posedge clk) begin
      if (rst_n && in_frame && tx_valid !== 1'b1) check("no_gap", tx_valid, 1);
      if (tx_valid === 1'b1 && tx_ready === 1'b1) in_frame <= (tx_last !== 1'b1);
      if (rx_stb === 1'b1) begin
         if (exp_q.size() == 0) check("extra_byte", 1, 0);
         else begin
            e = exp_q.pop_front();
            check("last_flag", rx_last, e[9]);
            if (e[9]) check("checksum", rx_byte, 8'hFF - sum);
            else if (!e[8]) check("frame_byte", rx_byte, e[7:0]);
            if (e[8]) ts = {ts[23:0], rx_byte};
            if (e[9] && idx == 45) ts_q.push_back(ts);
            if (idx >= 3) sum = sum + rx_byte;
            if (e[9]) sum = 8'h00;
            idx = e[9] ? 0 : idx + 1;
         end
      end
   end

   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (i = 0; i < 4; i++) begin
         rnd(2'(i));
         req(1, 0);
      end
      drain();
      $display("Test legacy status frames done");
      stall_en <= 1'b1;
      for (i = 0; i < 4; i++) begin
         rnd(2'(i));
         req(0, 1);
      end
      drain();
      $display("Test route frames with stalls done");
      rnd(2'b11);
      req(1, 1);
      @(posedge clk);
      // Requests while both slots are busy must leave no trace
      leg_valid <= 1'b1;
      rt_valid  <= 1'b1;
      repeat (3) @(posedge clk);
      leg_valid <= 1'b0;
      rt_valid  <= 1'b0;
      drain();
      $display("Test simultaneous and refused requests done");
      stall_en <= 1'b0;
      rnd(2'b10);
      req(0, 1);
      repeat (4000) @(posedge clk);
      rnd(2'b01);
      req(1, 1);
      drain();
      check("timestamp_count", ts_q.size(), tk_q.size());
      for (i = 1; i < ts_q.size(); i++) begin
         d = ts_q[i] - ts_q[i-1];
         x = (tk_q[i] - tk_q[i-1]) / tsrif_pkg::CYC_PER_US;
         check("timestamp_delta", (d == x || d == x + 1) ? x : d, x);
      end
      $display("Test timestamp spacing done");
      stop_test();
   end
endmodule // testbench
